// [rtl/divide_and_decimal_adjust_unit.sv]
// Divide and decimal adjust execution unit with divide-error trap.
`timescale 1ns/1ps
`include "divadj_regs.svh"
// What this block does
// - Unsigned word divide: high:accum by operand, quotient accum, remainder high.
// - Unsigned quotient above FFFFH or zero divisor raises the vector-0 trap.
// - Trap pushes status, segment, counter below stack, drops it six, loads vector.
// - Signed byte divide: accum word by 8-bit operand, quotient low, remainder high.
// - Signed byte quotient beyond plus or minus 127, or zero divisor, traps.
// - Signed word divide: high:accum by 16-bit operand into accum and high.
// - Signed word quotient beyond plus or minus 32767, or zero divisor, traps.
// - Signed remainder takes the dividend's sign; quotient truncates toward zero.
// - Fractional quotient bits are dropped, never rounded.
// - Unsigned memory divide takes 35 clocks, or 31 on wide even access.
// - Signed byte register divide takes 29 to 34 clocks by data.
// - Signed byte memory divide takes 35 to 40 clocks by data.
// - Signed word register divide takes 38 to 43 clocks by data.
// - Signed word memory divide takes 48 to 53, or 44 to 49 wide even.
// - Unpacked add adjust adds six, bumps high byte, sets both carries.
// - Unpacked subtract adjust subtracts six, drops high byte, sets both carries.
module divide_and_decimal_adjust_unit
  import divadj_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET,
  // Instruction request from the sequencer.
  input  wire logic        I_START,
  input  wire op_type      I_OP,
  input  wire logic        I_MEM_OPERAND,
  input  wire logic        I_WIDE_BUS,
  input  wire logic        I_EVEN_ADDR,
  // Register file values at the request.
  input  wire logic [15:0] I_ACCUM_WORD,
  input  wire logic [15:0] I_HIGH_WORD_REG,
  input  wire logic [15:0] I_OPERAND,
  input  wire logic [15:0] I_STATUS_WORD,
  input  wire logic [15:0] I_PROGRAM_SEG,
  input  wire logic [15:0] I_PROGRAM_COUNTER,
  input  wire logic [15:0] I_STACK_PTR,
  input  wire logic        I_AUX_CARRY,
  input  wire logic        I_CARRY,
  // Trap memory port.
  input  wire logic [7:0]  I_MEM_RDATA,
  output logic             O_MEM_WR,
  output logic             O_MEM_RD,
  output logic             O_MEM_STACK,
  output logic [15:0]      O_MEM_ADDR,
  output logic [7:0]       O_MEM_WDATA,
  // Completion and results.
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic             O_TRAP,
  output logic [15:0]      O_ACCUM_WORD,
  output logic [15:0]      O_HIGH_WORD_REG,
  output logic             O_AUX_CARRY,
  output logic             O_CARRY,
  output logic [15:0]      O_STACK_PTR,
  output logic [15:0]      O_PROGRAM_SEG,
  output logic [15:0]      O_PROGRAM_COUNTER,
  output logic             O_CLR_INT_ENABLE,
  output logic             O_CLR_SINGLE_STEP
);
  typedef struct packed {
    st_type      st;
    op_type      op;
    logic [5:0]  cnt;
    logic [7:0]  cyc;
    logic        mem;
    logic        fast;
    logic        neg_dvd;
    logic        neg_q;
    logic        bad;
    logic [2:0]  idx;
    logic        rd_dly;
    logic [1:0]  rd_idx;
    logic        div_start;
    logic [31:0] dvd;
    logic [15:0] dvs;
    logic [15:0] acc;
    logic [15:0] hi;
    logic        aux;
    logic        cy;
    logic [15:0] status_word;
    logic [15:0] seg;
    logic [15:0] pc;
    logic [15:0] sp;
    logic        mem_wr;
    logic        mem_rd;
    logic        mem_stack;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        busy;
    logic        done;
    logic        trap;
    logic        clr_ie;
    logic        clr_brk;
  } unit_type;

  unit_type    s_q;
  unit_type    s_d;
  logic [31:0] wide_dvd;
  logic [5:0]  extra;
  logic        nd;
  logic        ns;
  logic [15:0] q_sgn;
  logic [15:0] r_sgn;
  logic [7:0]  adj_low;
  logic [7:0]  adj_high;
  logic        adj_aux;
  logic        adj_carry;

  div_if dv ();

  // Divider; it starts from the registered request one cycle after entry.
  div_core u_div (
    .I_CLK_SYS (I_CLK_SYS),
    .I_RESET   (I_RESET),
    .dv        (dv.core)
  );

  // Decimal adjust works on the live inputs in the request cycle.
  bcd_adjust u_bcd (
    .i_op      (I_OP),
    .i_low     (I_ACCUM_WORD[7:0]),
    .i_high    (I_ACCUM_WORD[15:8]),
    .i_aux     (I_AUX_CARRY),
    .i_carry   (I_CARRY),
    .o_low     (adj_low),
    .o_high    (adj_high),
    .o_aux     (adj_aux),
    .o_carry   (adj_carry)
  );

  assign dv.start = s_q.div_start;
  assign dv.dvd   = s_q.dvd;
  assign dv.dvs   = s_q.dvs;

  // Sign fix-up of the magnitudes from the divider.
  assign q_sgn = s_q.neg_q ? -dv.quo : dv.quo;
  assign r_sgn = s_q.neg_dvd ? -dv.rem : dv.rem;

  // Sequencing of request, wait, result and trap.
  always_comb begin
    s_d           = s_q;
    s_d.done      = 1'b0;
    s_d.trap      = 1'b0;
    s_d.clr_ie    = 1'b0;
    s_d.clr_brk   = 1'b0;
    s_d.mem_wr    = 1'b0;
    s_d.mem_rd    = 1'b0;
    s_d.div_start = 1'b0;
    s_d.rd_dly    = s_q.mem_rd;
    s_d.rd_idx    = s_q.mem_addr[1:0];
    s_d.cyc       = (s_q.cyc == 8'hff) ? s_q.cyc : s_q.cyc + 8'h01;
    wide_dvd      = {I_HIGH_WORD_REG, I_ACCUM_WORD};
    nd            = 1'b0;
    ns            = 1'b0;
    extra         = 6'h00;
    case (s_q.st)
      st_idle: begin
        if (I_START) begin
          s_d.st    = st_run;
          s_d.busy  = 1'b1;
          s_d.cyc   = 8'h00;
          s_d.op    = I_OP;
          s_d.mem   = I_MEM_OPERAND;
          s_d.fast  = I_WIDE_BUS & I_EVEN_ADDR;
          s_d.bad   = 1'b0;
          s_d.acc   = I_ACCUM_WORD;
          s_d.hi    = I_HIGH_WORD_REG;
          s_d.aux   = I_AUX_CARRY;
          s_d.cy    = I_CARRY;
          s_d.status_word   = I_STATUS_WORD;
          s_d.seg   = I_PROGRAM_SEG;
          s_d.pc    = I_PROGRAM_COUNTER;
          s_d.sp    = I_STACK_PTR;
          case (I_OP)
            unsigned_divide_op: begin
              s_d.dvd       = wide_dvd;
              s_d.dvs       = I_OPERAND;
              s_d.neg_dvd   = 1'b0;
              s_d.neg_q     = 1'b0;
              s_d.div_start = 1'b1;
              s_d.cnt       = ((I_WIDE_BUS & I_EVEN_ADDR) ? `UDIV_CLK_FAST
                              : `UDIV_CLK_SLOW) - 6'h01;
            end
            signed_byte_divide_op: begin
              nd            = I_ACCUM_WORD[15];
              ns            = I_OPERAND[7];
              extra         = (nd ? `EXTRA_NEG_DVD : 6'h00)
                              + (ns ? `EXTRA_NEG_DVS : 6'h00);
              s_d.dvd       = {16'h0000,
                               nd ? -I_ACCUM_WORD : I_ACCUM_WORD};
              s_d.dvs       = {8'h00,
                               ns ? -I_OPERAND[7:0] : I_OPERAND[7:0]};
              s_d.neg_dvd   = nd;
              s_d.neg_q     = nd ^ ns;
              s_d.div_start = 1'b1;
              if (I_MEM_OPERAND) begin
                s_d.cnt = `SBDIV_MEM_CLK + extra - 6'h01;
              end else begin
                s_d.cnt = `SBDIV_REG_CLK + extra - 6'h01;
              end
            end
            signed_word_divide_op: begin
              nd            = wide_dvd[31];
              ns            = I_OPERAND[15];
              extra         = (nd ? `EXTRA_NEG_DVD : 6'h00)
                              + (ns ? `EXTRA_NEG_DVS : 6'h00);
              s_d.dvd       = nd ? -wide_dvd : wide_dvd;
              s_d.dvs       = ns ? -I_OPERAND : I_OPERAND;
              s_d.neg_dvd   = nd;
              s_d.neg_q     = nd ^ ns;
              s_d.div_start = 1'b1;
              if (!I_MEM_OPERAND) begin
                s_d.cnt = `SWDIV_REG_CLK + extra - 6'h01;
              end else if (I_WIDE_BUS & I_EVEN_ADDR) begin
                s_d.cnt = `SWDIV_MEM_FAST + extra - 6'h01;
              end else begin
                s_d.cnt = `SWDIV_MEM_SLOW + extra - 6'h01;
              end
            end
            default: begin
              // Adjusts finish with their result captured right here.
              s_d.acc = {adj_high, adj_low};
              s_d.aux = adj_aux;
              s_d.cy  = adj_carry;
              s_d.cnt = ((I_OP == unpacked_sub_adjust_op) ? `SUB_ADJ_CLK
                        : `ADD_ADJ_CLK) - 6'h01;
            end
          endcase
        end
      end
      st_run: begin
        // The divider answers long before the count runs out.
        if (dv.done) begin
          case (s_q.op)
            unsigned_divide_op: begin
              s_d.bad = dv.ovf;
              s_d.acc = dv.quo;
              s_d.hi  = dv.rem;
            end
            signed_byte_divide_op: begin
              s_d.bad = dv.ovf || (dv.quo > `BYTE_Q_MAX);
              s_d.acc = {r_sgn[7:0], q_sgn[7:0]};
            end
            signed_word_divide_op: begin
              s_d.bad = dv.ovf || (dv.quo > `WORD_Q_MAX);
              s_d.acc = q_sgn;
              s_d.hi  = r_sgn;
            end
            default: begin
              s_d.bad = 1'b0;
            end
          endcase
        end
        s_d.cnt = s_q.cnt - 6'h01;
        if (s_q.cnt == 6'h01) begin
          if (s_q.bad) begin
            s_d.st  = st_push;
            s_d.idx = 3'h0;
          end else begin
            s_d.st   = st_idle;
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
          end
        end
      end
      st_push: begin
        // Bytes go high first, walking down from just below the stack.
        s_d.mem_wr    = 1'b1;
        s_d.mem_stack = 1'b1;
        s_d.mem_addr  = s_q.sp - 16'h0001 - {13'h0000, s_q.idx};
        case (s_q.idx)
          3'h0:    s_d.mem_wdata = s_q.status_word[15:8];
          3'h1:    s_d.mem_wdata = s_q.status_word[7:0];
          3'h2:    s_d.mem_wdata = s_q.seg[15:8];
          3'h3:    s_d.mem_wdata = s_q.seg[7:0];
          3'h4:    s_d.mem_wdata = s_q.pc[15:8];
          default: s_d.mem_wdata = s_q.pc[7:0];
        endcase
        s_d.idx = s_q.idx + 3'h1;
        if (s_q.idx == `PUSH_LAST) begin
          s_d.st  = st_vec;
          s_d.idx = 3'h0;
        end
      end
      st_vec: begin
        s_d.mem_rd    = 1'b1;
        s_d.mem_stack = 1'b0;
        s_d.mem_addr  = `VEC_BASE + {13'h0000, s_q.idx};
        s_d.idx       = s_q.idx + 3'h1;
        if (s_q.idx == `VEC_LAST) begin
          s_d.st = st_fin;
        end
      end
      st_fin: begin
        if (s_q.rd_dly && (s_q.rd_idx == 2'h3)) begin
          s_d.st      = st_idle;
          s_d.busy    = 1'b0;
          s_d.done    = 1'b1;
          s_d.trap    = 1'b1;
          s_d.clr_ie  = 1'b1;
          s_d.clr_brk = 1'b1;
          s_d.sp      = s_q.sp - `STACK_DROP;
        end
      end
      default: begin
        s_d.st = st_idle;
      end
    endcase
    // Vector bytes return one cycle after their read strobe; the address
    // has moved on by then, so the delayed copy picks the byte lane.
    if (s_q.rd_dly) begin
      case (s_q.rd_idx)
        2'h0:    s_d.pc[7:0]   = I_MEM_RDATA;
        2'h1:    s_d.pc[15:8]  = I_MEM_RDATA;
        2'h2:    s_d.seg[7:0]  = I_MEM_RDATA;
        default: s_d.seg[15:8] = I_MEM_RDATA;
      endcase
    end
  end

  // State register.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign O_MEM_WR          = s_q.mem_wr;
  assign O_MEM_RD          = s_q.mem_rd;
  assign O_MEM_STACK       = s_q.mem_stack;
  assign O_MEM_ADDR        = s_q.mem_addr;
  assign O_MEM_WDATA       = s_q.mem_wdata;
  assign O_BUSY            = s_q.busy;
  assign O_DONE            = s_q.done;
  assign O_TRAP            = s_q.trap;
  assign O_ACCUM_WORD      = s_q.acc;
  assign O_HIGH_WORD_REG   = s_q.hi;
  assign O_AUX_CARRY       = s_q.aux;
  assign O_CARRY           = s_q.cy;
  assign O_STACK_PTR       = s_q.sp;
  assign O_PROGRAM_SEG     = s_q.seg;
  assign O_PROGRAM_COUNTER = s_q.pc;
  assign O_CLR_INT_ENABLE  = s_q.clr_ie;
  assign O_CLR_SINGLE_STEP = s_q.clr_brk;

  // Clock counts from request to answer, the first cycle after the request being zero.
  udiv_time_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    O_DONE && !O_TRAP && s_q.op == unsigned_divide_op
    |-> s_q.cyc == (s_q.fast ? 8'd30 : 8'd34))
    else $error("unsigned divide time wrong");
  sbyte_reg_time_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET)
    O_DONE && !O_TRAP && s_q.op == signed_byte_divide_op && !s_q.mem
    |-> s_q.cyc inside {[8'd28:8'd33]})
    else $error("byte register divide time wrong");
  sbyte_mem_time_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET)
    O_DONE && !O_TRAP && s_q.op == signed_byte_divide_op && s_q.mem
    |-> s_q.cyc inside {[8'd34:8'd39]})
    else $error("byte memory divide time wrong");
  sword_reg_time_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET)
    O_DONE && !O_TRAP && s_q.op == signed_word_divide_op && !s_q.mem
    |-> s_q.cyc inside {[8'd37:8'd42]})
    else $error("word register divide time wrong");
  sword_mem_time_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET)
    O_DONE && !O_TRAP && s_q.op == signed_word_divide_op && s_q.mem
    |-> (s_q.fast ? (s_q.cyc inside {[8'd43:8'd48]})
                  : (s_q.cyc inside {[8'd47:8'd52]})))
    else $error("word memory divide time wrong");
  // Trap pushes exactly six bytes, starting just below the stack.
  push_bytes_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    $rose(O_MEM_WR) |-> O_MEM_WR[*6]
    ##0 O_MEM_ADDR == O_STACK_PTR - 16'h0006 ##1 !O_MEM_WR)
    else $error("trap push length wrong");
  trap_end_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    O_TRAP |-> O_DONE && O_CLR_INT_ENABLE && O_CLR_SINGLE_STEP
    && O_STACK_PTR == $past(O_STACK_PTR) - 16'h0006)
    else $error("trap ending wrong");
  // Quotients never reach the excluded most negative value.
  byte_limit_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    O_DONE && !O_TRAP && s_q.op == signed_byte_divide_op
    |-> O_ACCUM_WORD[7:0] != 8'h80)
    else $error("byte quotient out of range");
  word_limit_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    O_DONE && !O_TRAP && s_q.op == signed_word_divide_op
    |-> O_ACCUM_WORD != 16'h8000)
    else $error("word quotient out of range");
  rem_sign_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    O_DONE && !O_TRAP && s_q.op == signed_word_divide_op
    && O_HIGH_WORD_REG != 16'h0000 |-> O_HIGH_WORD_REG[15] == s_q.neg_dvd)
    else $error("remainder sign wrong");
  nibble_clear_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET)
    O_DONE && (s_q.op == unpacked_add_adjust_op
    || s_q.op == unpacked_sub_adjust_op) |-> O_ACCUM_WORD[7:4] == 4'h0)
    else $error("upper nibble not cleared");
endmodule

// [rtl/divadj_regs.svh]
// Constants for the divide and decimal adjust unit.
`ifndef DIVADJ_REGS_SVH
`define DIVADJ_REGS_SVH
`define UDIV_CLK_SLOW   6'h23
`define UDIV_CLK_FAST   6'h1f
`define SBDIV_REG_CLK   6'h1d
`define SBDIV_MEM_CLK   6'h23
`define SWDIV_REG_CLK   6'h26
`define SWDIV_MEM_SLOW  6'h30
`define SWDIV_MEM_FAST  6'h2c
`define ADD_ADJ_CLK     6'h03
`define SUB_ADJ_CLK     6'h07
`define EXTRA_NEG_DVD   6'h02
`define EXTRA_NEG_DVS   6'h03
`define PUSH_LAST       3'h5
`define VEC_LAST        3'h3
`define STACK_DROP      16'h0006
`define VEC_BASE        16'h0000
`define BYTE_Q_MAX      16'h007f
`define WORD_Q_MAX      16'h7fff
`define NIB_MASK        8'h0f
`define NIB_LIMIT       8'h09
`define LOW_FIX         8'h06
`define HIGH_FIX        8'h60
`define HIGH_LIMIT      8'h9f
`define DIV_STEPS       5'h10
`endif

// [rtl/divadj_pkg.sv]
// Types shared by the divide and decimal adjust unit.
package divadj_pkg;
  typedef enum logic [2:0] {
    unsigned_divide_op,
    signed_byte_divide_op,
    signed_word_divide_op,
    unpacked_add_adjust_op,
    packed_add_adjust_op,
    unpacked_sub_adjust_op
  } op_type;
  typedef enum logic [2:0] {st_idle, st_run, st_push, st_vec, st_fin} st_type;
endpackage

// [rtl/div_if.sv]
// Request and answer wires between the unit and its divider.
`timescale 1ns/1ps
interface div_if;
  logic        start;
  logic [31:0] dvd;
  logic [15:0] dvs;
  logic        done;
  logic [15:0] quo;
  logic [15:0] rem;
  logic        ovf;
  modport core (input start, dvd, dvs, output done, quo, rem, ovf);
  modport user (output start, dvd, dvs, input done, quo, rem, ovf);
endinterface

// [rtl/div_core.sv]
// Iterative restoring divider, 32 by 16 bits, unsigned magnitudes.
`timescale 1ns/1ps
`include "divadj_regs.svh"
module div_core (
  // Clock and reset.
  input  wire logic I_CLK_SYS,
  input  wire logic I_RESET,
  // Divider request and answer.
  div_if.core       dv
);
  typedef struct packed {
    logic [16:0] rem;
    logic [15:0] quo;
    logic [15:0] dvs;
    logic [4:0]  cnt;
    logic        busy;
    logic        done;
    logic        ovf;
  } core_type;
  core_type    s_q;
  core_type    s_d;
  logic [16:0] shifted;
  logic [16:0] trial;

  // One quotient bit per cycle; the remainder left is the truncated part.
  always_comb begin
    s_d     = s_q;
    s_d.done = 1'b0;
    shifted = {s_q.rem[15:0], s_q.quo[15]};
    trial   = shifted - {1'b0, s_q.dvs};
    if (dv.start) begin
      s_d.rem  = {1'b0, dv.dvd[31:16]};
      s_d.quo  = dv.dvd[15:0];
      s_d.dvs  = dv.dvs;
      s_d.cnt  = `DIV_STEPS;
      s_d.busy = 1'b1;
      s_d.ovf  = (dv.dvd[31:16] >= dv.dvs);
    end else if (s_q.busy) begin
      if (!trial[16]) begin
        s_d.rem = trial;
        s_d.quo = {s_q.quo[14:0], 1'b1};
      end else begin
        s_d.rem = shifted;
        s_d.quo = {s_q.quo[14:0], 1'b0};
      end
      s_d.cnt = s_q.cnt - 5'h01;
      if (s_q.cnt == 5'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dv.done = s_q.done;
  assign dv.quo  = s_q.quo;
  assign dv.rem  = s_q.rem[15:0];
  assign dv.ovf  = s_q.ovf;

  // The answer follows a request after a fixed sixteen steps.
  core_steps_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    dv.start |-> ##17 dv.done) else $error("divider answer late");
  // A valid remainder is always smaller than the divisor.
  rem_small_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    dv.done && !dv.ovf |-> dv.rem < s_q.dvs)
    else $error("remainder not below divisor");
endmodule

// [rtl/bcd_adjust.sv]
// Combinational decimal adjust of the low and high accumulator bytes.
`timescale 1ns/1ps
`include "divadj_regs.svh"
module bcd_adjust
  import divadj_pkg::*;
(
  // Operation and operands.
  input  wire op_type     i_op,
  input  wire logic [7:0] i_low,
  input  wire logic [7:0] i_high,
  input  wire logic       i_aux,
  input  wire logic       i_carry,
  // Adjusted values.
  output logic [7:0]      o_low,
  output logic [7:0]      o_high,
  output logic            o_aux,
  output logic            o_carry
);
  logic low_fix;

  // Values pass through when no correction applies, except that unpacked adjusts clear the low byte's upper nibble.
  always_comb begin
    low_fix = ((i_low & `NIB_MASK) > `NIB_LIMIT) || i_aux;
    o_low   = i_low;
    o_high  = i_high;
    o_aux   = i_aux;
    o_carry = i_carry;
    case (i_op)
      unpacked_add_adjust_op: begin
        if (low_fix) begin
          o_low   = i_low + `LOW_FIX;
          o_high  = i_high + 8'h01;
          o_aux   = 1'b1;
          o_carry = 1'b1;
        end
        o_low = o_low & `NIB_MASK;
      end
      packed_add_adjust_op: begin
        if (low_fix) begin
          o_low   = i_low + `LOW_FIX;
          o_carry = i_carry | i_aux;
          o_aux   = 1'b1;
        end
        // The high test sees the byte after the low correction.
        if ((o_low > `HIGH_LIMIT) || o_carry) begin
          o_low   = o_low + `HIGH_FIX;
          o_carry = 1'b1;
        end
      end
      unpacked_sub_adjust_op: begin
        if (low_fix) begin
          o_low   = i_low - `LOW_FIX;
          o_high  = i_high - 8'h01;
          o_aux   = 1'b1;
          o_carry = 1'b1;
        end
        o_low = o_low & `NIB_MASK;
      end
      default: begin
        o_low = i_low;
      end
    endcase
  end
endmodule

// [test/trap_mem_model.sv]
// Memory model that holds the vector table and records pushed bytes.
`timescale 1ns/1ps
module trap_mem_model #(
  parameter logic [31:0] VEC = 32'h5678_1234
) (
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  output logic      [47:0] pushed
);
  initial rdata = 8'h00;
  initial pushed = 48'h0;
  // Reads answer one cycle later; idle, the bus toggles so stale data fails.
  always @(posedge clk) begin
    if (rd) rdata <= VEC[addr[1:0]*8 +: 8];
    else rdata <= ~rdata;
    if (wr) pushed <= {pushed[39:0], wdata};
  end
endmodule

// [test/divide_and_decimal_adjust_unit_tb.sv]
// Self-checking bench for the divide and decimal adjust unit.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  miscompares++; $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module divide_and_decimal_adjust_unit_tb
  import divadj_pkg::*;
;
  logic clk = 0, rst = 1, start = 0, mem = 0, fast = 0, ac = 0, cy = 0;
  op_type op = unsigned_divide_op;
  logic [15:0] aw = 0, dw = 0, od = 0, maddr, oaw, odw, osp, oseg, opc;
  logic [7:0]  rdata, wd;
  logic [47:0] pushed;
  logic wr, rd, stk, busy, done, trap, oac, ocy, cie, css;
  int miscompares = 0, comparisons = 0;
  divide_and_decimal_adjust_unit uut (
    .I_CLK_SYS(clk), .I_RESET(rst), .I_START(start), .I_OP(op),
    .I_MEM_OPERAND(mem), .I_WIDE_BUS(fast), .I_EVEN_ADDR(fast),
    .I_ACCUM_WORD(aw), .I_HIGH_WORD_REG(dw), .I_OPERAND(od),
    .I_STATUS_WORD(16'hf202), .I_PROGRAM_SEG(16'h2000),
    .I_PROGRAM_COUNTER(16'h0100), .I_STACK_PTR(16'h0ffe),
    .I_AUX_CARRY(ac), .I_CARRY(cy), .I_MEM_RDATA(rdata),
    .O_MEM_WR(wr), .O_MEM_RD(rd), .O_MEM_STACK(stk), .O_MEM_ADDR(maddr),
    .O_MEM_WDATA(wd), .O_BUSY(busy), .O_DONE(done), .O_TRAP(trap),
    .O_ACCUM_WORD(oaw), .O_HIGH_WORD_REG(odw), .O_AUX_CARRY(oac),
    .O_CARRY(ocy), .O_STACK_PTR(osp), .O_PROGRAM_SEG(oseg),
    .O_PROGRAM_COUNTER(opc), .O_CLR_INT_ENABLE(cie),
    .O_CLR_SINGLE_STEP(css));
  trap_mem_model mdl (.clk(clk), .rd(rd), .wr(wr), .addr(maddr),
    .wdata(wd), .rdata(rdata), .pushed(pushed));
  // Clock of 40 ns period.
  initial forever #20 clk = ~clk;
  task automatic summarize;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One operation: edges from the taking edge to the done pulse, and trap.
  task automatic go(input op_type o, input logic m, f,
      input logic [15:0] a, h, d, input logic c1, c2, input int n,
      input logic t);
    int k;
    op = o; mem = m; fast = f; aw = a; dw = h; od = d; ac = c1; cy = c2;
    start = 1;
    @(posedge clk);
    #1 start = 0;
    `CHK(busy, 1'b1)
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (done !== 1'b1 && k < 200);
    `CHK(k, n)
    `CHK(trap, t)
  endtask
  // Watchdog sized well above the whole sequence; a hang ends the run.
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize;
  end
  // Main sequence of operations with expected results.
  initial begin
    repeat (20) @(posedge clk);
    #1 `CHK({done, busy, trap, wr, rd}, 5'h0)
    rst = 0;
    go(unsigned_divide_op, 1, 1, 16'h2197, 16'h0348, 16'h2000, 0, 0, 30, 0);
    `CHK({oaw, odw}, 32'h1a41_0197)
    go(unsigned_divide_op, 1, 0, 16'h0064, 16'h0000, 16'h0005, 0, 0, 34, 0);
    `CHK({oaw, odw}, 32'h0014_0000)
    go(signed_byte_divide_op, 0, 0, 16'hff09, 0, 16'h0003, 0, 0, 30, 0);
    `CHK(oaw, 16'hffae)
    go(signed_byte_divide_op, 1, 0, 16'h04d2, 0, 16'h00ec, 0, 0, 37, 0);
    `CHK(oaw, 16'h0ec3)
    go(signed_byte_divide_op, 0, 0, 16'h007f, 0, 16'h0001, 0, 0, 28, 0);
    `CHK(oaw, 16'h007f)
    go(signed_word_divide_op, 0, 0, 16'h4567, 16'h0123, 16'h1000, 0, 0, 37, 0);
    `CHK({oaw, odw}, 32'h1234_0567)
    go(signed_word_divide_op, 1, 0, 16'hffde, 16'hffff, 16'hfffe, 0, 0, 52, 0);
    `CHK({oaw, odw}, 32'h0011_0000)
    go(unsigned_divide_op, 1, 0, 16'h1234, 16'h0000, 16'h0000, 0, 0, 46, 1);
    `CHK({cie, css, osp, oseg, opc}, 50'h3_0ff8_5678_1234)
    `CHK(pushed, 48'hf202_2000_0100)
    `CHK({stk, busy}, 2'b00)
    go(signed_byte_divide_op, 0, 0, 16'h0080, 0, 16'h0001, 0, 0, 40, 1);
    go(signed_word_divide_op, 0, 0, 16'h8000, 16'h0000, 16'h0001, 0, 0, 49, 1);
    go(unpacked_add_adjust_op, 0, 0, 16'h010b, 0, 0, 0, 0, 2, 0);
    `CHK({oaw, oac, ocy}, {16'h0201, 2'b11})
    go(unpacked_add_adjust_op, 0, 0, 16'h0135, 0, 0, 0, 0, 2, 0);
    `CHK({oaw, oac, ocy}, {16'h0105, 2'b00})
    go(packed_add_adjust_op, 0, 0, 16'h001b, 0, 0, 0, 0, 2, 0);
    `CHK({oaw, oac, ocy}, {16'h0021, 2'b10})
    go(packed_add_adjust_op, 0, 0, 16'h009a, 0, 0, 0, 0, 2, 0);
    `CHK({oaw, oac, ocy}, {16'h0000, 2'b11})
    go(packed_add_adjust_op, 0, 0, 16'h0045, 0, 0, 0, 1, 2, 0);
    `CHK({oaw, oac, ocy}, {16'h00a5, 2'b01})
    go(unpacked_sub_adjust_op, 0, 0, 16'h030f, 0, 0, 0, 0, 6, 0);
    `CHK({oaw, oac, ocy}, {16'h0209, 2'b11})
    summarize;
  end
endmodule
